/* rtl/nps_pkg.sv */
package nps_pkg;
  localparam int CLK_MHZ  = 125;
  // strobe timing in ns, then synchronizer depth in cycles
  localparam int T_WP_NS  = 12;
  localparam int T_WH_NS  = 10;
  localparam int T_WB_NS  = 100;
  localparam int T_REA_NS = 20;
  localparam int SYNC_CYC = 2;

  // least time in whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc

  localparam int COL_W = 13;
  localparam int ROW_W = 17;
  localparam logic [COL_W-1:0] COL_SPARE_BASE = 13'h1000;
  localparam logic [COL_W-1:0] COL_PAGE_END   = 13'h1080;
  localparam int SEC_MAIN_B  = 512;
  localparam int SEC_SPARE_B = 16;
  localparam int DIST_BIT    = 6;
  localparam int PAGE_BITS   = 6;
  localparam int MAX_PROG_DEF = 4;

  localparam logic [7:0] CMD_READ    = 8'h00;
  localparam logic [7:0] CMD_CB_CONF = 8'h35;
  localparam logic [7:0] CMD_PROG    = 8'h80;
  localparam logic [7:0] CMD_PROG_B  = 8'h81;
  localparam logic [7:0] CMD_COLCHG  = 8'h85;
  localparam logic [7:0] CMD_CONF    = 8'h10;
  localparam logic [7:0] CMD_DIST    = 8'h11;
  localparam logic [7:0] CMD_ERASE   = 8'h60;
  localparam logic [7:0] CMD_ERASE_C = 8'hd0;
  localparam logic [7:0] CMD_STAT    = 8'h70;
  localparam logic [7:0] CMD_STAT2   = 8'h71;
  localparam logic [7:0] CMD_RESET   = 8'hff;

  localparam int ST_FAIL = 0;
  localparam int ST_D0   = 1;
  localparam int ST_D1   = 2;
  localparam int ST_RDY  = 6;
  localparam int ST_WP   = 7;

  typedef enum logic [2:0] {
    OP_PROG, OP_PROG2, OP_ERASE, OP_ERASE2,
    OP_CB_READ, OP_CB_PROG, OP_STATUS, OP_RESET
  } nps_op_t;

  typedef enum logic [3:0] {
    K_CMD, K_ADR_A, K_ADR_B, K_ROW_A, K_ROW_B,
    K_DATA, K_BUSY, K_STAT, K_END
  } nps_kind_t;

  typedef struct packed {
    nps_kind_t  kind;
    logic [7:0] code;
  } nps_step_t;

  typedef struct packed {
    nps_op_t          op;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row_a;
    logic [ROW_W-1:0] row_b;
    logic             with_data;
  } nps_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } nps_data_t;

  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
  } nps_pins_t;
endpackage : nps_pkg

/* rtl/nps_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module nps_ctrl
  import nps_pkg::*;
#(
  parameter int MAX_PROG = MAX_PROG_DEF
) (
  input  wire logic             CLK_IN,          // 125 MHz clock
  input  wire logic             RST_N_IN,        // async reset, low
  input  wire logic             REQ_VALID_IN,    // operation request
  input  wire nps_req_t         REQ_IN,          // operation and addresses
  output logic                  REQ_READY_OUT,   // idle, request taken
  input  wire logic             DATA_VALID_IN,   // write byte valid
  input  wire nps_data_t        DATA_IN,         // write byte and last
  output logic                  DATA_READY_OUT,  // write byte taken
  input  wire logic             COL_CHG_IN,      // column change request
  input  wire logic [COL_W-1:0] COL_IN,          // new column
  output logic                  COL_CHG_ACK_OUT, // column change taken
  input  wire logic             PROTECT_IN,      // protect while idle
  output logic                  DONE_OUT,        // operation finished
  output logic                  ERR_OUT,         // request refused
  output logic [7:0]            STATUS_OUT,      // last status byte
  output logic                  FAIL_OUT,        // status fail bit
  output nps_pins_t             PINS_OUT,        // strobe pins
  input  wire logic [7:0]       IO_IN,           // io bus level
  output logic [7:0]            IO_OUT,          // io bus drive
  output logic                  IO_OE_OUT,       // io bus enable
  input  wire logic             RB_IN            // ready/busy pin
);
  localparam logic [3:0] WP_C  = 4'(ns2cyc(T_WP_NS));
  localparam logic [3:0] WH_C  = 4'(ns2cyc(T_WH_NS));
  localparam logic [3:0] WB_C  = 4'(ns2cyc(T_WB_NS));
  localparam logic [3:0] REA_C = 4'(ns2cyc(T_REA_NS) + SYNC_CYC);

  if (MAX_PROG < 1 || MAX_PROG > 7) begin : g_chk_prog
    $error("MAX_PROG must lie in 1..7");
  end
  if (ns2cyc(T_WB_NS) > 15 || ns2cyc(T_REA_NS) + SYNC_CYC > 15) begin : g_chk_cnt
    $error("strobe counts exceed counter width");
  end

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_LOAD  = 8'h02,
    ST_LOW   = 8'h04,
    ST_HIGH  = 8'h08,
    ST_WB    = 8'h10,
    ST_BUSY  = 8'h20,
    ST_RLOW  = 8'h40,
    ST_RHIGH = 8'h80
  } nps_state_t;

  function automatic nps_step_t mk(input nps_kind_t k, input logic [7:0] c);
    nps_step_t s;
    s.kind = k;
    s.code = c;
    return s;
  endfunction : mk

  function automatic nps_step_t seq(input nps_op_t op, input logic [3:0] p);
    nps_step_t s;
    s = mk(K_END, 8'h00);
    case (op)
      OP_PROG: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_PROG);
          4'h1: s = mk(K_ADR_A, 8'h00);
          4'h2: s = mk(K_DATA, 8'h00);
          4'h3: s = mk(K_CMD, CMD_CONF);
          4'h4: s = mk(K_BUSY, 8'h00);
          4'h5: s = mk(K_CMD, CMD_STAT);
          4'h6: s = mk(K_STAT, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      OP_PROG2: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_PROG);
          4'h1: s = mk(K_ADR_A, 8'h00);
          4'h2: s = mk(K_DATA, 8'h00);
          4'h3: s = mk(K_CMD, CMD_DIST);
          4'h4: s = mk(K_BUSY, 8'h00);
          4'h5: s = mk(K_CMD, CMD_PROG_B);
          4'h6: s = mk(K_ADR_B, 8'h00);
          4'h7: s = mk(K_DATA, 8'h00);
          4'h8: s = mk(K_CMD, CMD_CONF);
          4'h9: s = mk(K_BUSY, 8'h00);
          4'ha: s = mk(K_CMD, CMD_STAT2);
          4'hb: s = mk(K_STAT, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      OP_ERASE: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_ERASE);
          4'h1: s = mk(K_ROW_A, 8'h00);
          4'h2: s = mk(K_CMD, CMD_ERASE_C);
          4'h3: s = mk(K_BUSY, 8'h00);
          4'h4: s = mk(K_CMD, CMD_STAT);
          4'h5: s = mk(K_STAT, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      OP_ERASE2: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_ERASE);
          4'h1: s = mk(K_ROW_A, 8'h00);
          4'h2: s = mk(K_CMD, CMD_ERASE);
          4'h3: s = mk(K_ROW_B, 8'h00);
          4'h4: s = mk(K_CMD, CMD_ERASE_C);
          4'h5: s = mk(K_BUSY, 8'h00);
          4'h6: s = mk(K_CMD, CMD_STAT2);
          4'h7: s = mk(K_STAT, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      OP_CB_READ: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_READ);
          4'h1: s = mk(K_ADR_A, 8'h00);
          4'h2: s = mk(K_CMD, CMD_CB_CONF);
          4'h3: s = mk(K_BUSY, 8'h00);
          4'h4: s = mk(K_CMD, CMD_STAT);
          4'h5: s = mk(K_STAT, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      OP_CB_PROG: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_COLCHG);
          4'h1: s = mk(K_ADR_A, 8'h00);
          4'h2: s = mk(K_DATA, 8'h00);
          4'h3: s = mk(K_CMD, CMD_CONF);
          4'h4: s = mk(K_BUSY, 8'h00);
          4'h5: s = mk(K_CMD, CMD_STAT);
          4'h6: s = mk(K_STAT, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      OP_STATUS: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_STAT);
          4'h1: s = mk(K_STAT, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      OP_RESET: begin
        case (p)
          4'h0: s = mk(K_CMD, CMD_RESET);
          4'h1: s = mk(K_BUSY, 8'h00);
          default: s = mk(K_END, 8'h00);
        endcase
      end
      default: s = mk(K_END, 8'h00);
    endcase
    return s;
  endfunction : seq

  // five-cycle address: column low, column high, row low, mid, top
  function automatic logic [7:0] addr_byte(input logic [COL_W-1:0] col,
                                           input logic [ROW_W-1:0] row,
                                           input logic [2:0]       idx);
    logic [7:0] b;
    case (idx)
      3'h0:    b = col[7:0];
      3'h1:    b = {3'h0, col[12:8]};
      3'h2:    b = row[7:0];
      3'h3:    b = row[15:8];
      default: b = {7'h00, row[16]};
    endcase
    return b;
  endfunction : addr_byte

  nps_state_t       state_r, state_nxt;
  logic [3:0]       pos_r, pos_nxt, cnt_r, cnt_nxt;
  logic [2:0]       acnt_r, acnt_nxt, pgcnt_r, pgcnt_nxt;
  logic [1:0]       chg_r, chg_nxt;
  nps_req_t         req_r, req_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic [ROW_W-1:0] pgrow_r, pgrow_nxt;
  logic [7:0]       io_r, io_nxt, stat_r, stat_nxt;
  logic             oe_r, oe_nxt, cle_r, cle_nxt, ale_r, ale_nxt;
  logic             we_r, we_nxt, re_r, re_nxt, ce_r, ce_nxt, wp_r, wp_nxt;
  logic             done_r, done_nxt, err_r, err_nxt;
  logic             cbv_r, cbv_nxt, cbd_r, cbd_nxt;
  logic             rb_s1, rb_s2;
  logic [7:0]       io_s1, io_s2;
  logic             go;

  wire nps_step_t        cur     = seq(req_r.op, pos_r);
  wire logic             is_data = (state_r == ST_LOAD) && (cur.kind == K_DATA)
                                   && req_r.with_data && (chg_r == 2'h0);
  wire logic             row_b   = (cur.kind == K_ADR_B) || (cur.kind == K_ROW_B);
  wire logic             row_only = (cur.kind == K_ROW_A) || (cur.kind == K_ROW_B);
  wire logic [ROW_W-1:0] row_sel = row_b ? req_r.row_b : req_r.row_a;
  wire logic [2:0]       aidx    = row_only ? acnt_r + 3'h2 : acnt_r;
  wire logic [2:0]       alast   = row_only ? 3'h2 : 3'h4;
  wire logic             two_op  = (REQ_IN.op == OP_PROG2) || (REQ_IN.op == OP_ERASE2);
  wire logic             prog_op = (REQ_IN.op == OP_PROG) || (REQ_IN.op == OP_PROG2)
                                   || (REQ_IN.op == OP_CB_PROG);
  wire logic bad_col  = prog_op && REQ_IN.with_data && (REQ_IN.col >= COL_PAGE_END);
  wire logic bad_dist = two_op && (REQ_IN.row_a[DIST_BIT] == REQ_IN.row_b[DIST_BIT]);
  wire logic bad_page = (REQ_IN.op == OP_PROG2) &&
                        (REQ_IN.row_a[PAGE_BITS-1:0] != REQ_IN.row_b[PAGE_BITS-1:0]);
  wire logic bad_cb   = (REQ_IN.op == OP_CB_PROG) &&
                        (!cbv_r || (REQ_IN.row_a[DIST_BIT] != cbd_r));
  wire logic same_pg  = (REQ_IN.row_a == pgrow_r);
  wire logic bad_cnt  = prog_op && same_pg && (pgcnt_r >= 3'(MAX_PROG));
  wire logic bad_req  = bad_col || bad_dist || bad_page || bad_cb || bad_cnt;

  assign REQ_READY_OUT   = (state_r == ST_IDLE);
  assign DATA_READY_OUT  = is_data && !COL_CHG_IN && DATA_VALID_IN;
  assign COL_CHG_ACK_OUT = is_data && COL_CHG_IN && (COL_IN < COL_PAGE_END);
  assign DONE_OUT        = done_r;
  assign ERR_OUT         = err_r;
  assign STATUS_OUT      = stat_r;
  assign FAIL_OUT        = stat_r[ST_FAIL];
  assign IO_OUT          = io_r;
  assign IO_OE_OUT       = oe_r;
  assign PINS_OUT        = '{cle: cle_r, ale: ale_r, ce_n: ce_r, we_n: we_r,
                             re_n: re_r, wp_n: wp_r};

  always_comb begin
    state_nxt = state_r;
    pos_nxt   = pos_r;
    cnt_nxt   = cnt_r;
    acnt_nxt  = acnt_r;
    chg_nxt   = chg_r;
    req_nxt   = req_r;
    col_nxt   = col_r;
    pgrow_nxt = pgrow_r;
    pgcnt_nxt = pgcnt_r;
    io_nxt    = io_r;
    oe_nxt    = oe_r;
    cle_nxt   = cle_r;
    ale_nxt   = ale_r;
    we_nxt    = we_r;
    re_nxt    = re_r;
    stat_nxt  = stat_r;
    cbv_nxt   = cbv_r;
    cbd_nxt   = cbd_r;
    done_nxt  = 1'b0;
    err_nxt   = 1'b0;
    go        = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (REQ_VALID_IN && bad_req) begin
          err_nxt = 1'b1;
        end else if (REQ_VALID_IN) begin
          req_nxt   = REQ_IN;
          col_nxt   = REQ_IN.col;
          pos_nxt   = 4'h0;
          acnt_nxt  = 3'h0;
          chg_nxt   = 2'h0;
          state_nxt = ST_LOAD;
          if (prog_op) begin
            pgrow_nxt = REQ_IN.row_a;
            pgcnt_nxt = same_pg ? pgcnt_r + 3'h1 : 3'h1;
          end
        end
      end
      ST_LOAD: begin
        case (cur.kind)
          K_CMD: begin
            io_nxt  = cur.code;
            cle_nxt = 1'b1;
            go      = 1'b1;
            pos_nxt = pos_r + 4'h1;
          end
          K_ADR_A, K_ADR_B, K_ROW_A, K_ROW_B: begin
            io_nxt   = addr_byte(col_r, row_sel, aidx);
            ale_nxt  = 1'b1;
            go       = 1'b1;
            acnt_nxt = (acnt_r == alast) ? 3'h0 : acnt_r + 3'h1;
            pos_nxt  = (acnt_r == alast) ? pos_r + 4'h1 : pos_r;
          end
          K_DATA: begin
            if (!req_r.with_data) begin
              pos_nxt = pos_r + 4'h1;
            end else if (chg_r != 2'h0) begin
              io_nxt  = addr_byte(col_r, row_sel, {1'b0, chg_r - 2'h1});
              ale_nxt = 1'b1;
              go      = 1'b1;
              chg_nxt = (chg_r == 2'h2) ? 2'h0 : 2'h2;
            end else if (COL_CHG_ACK_OUT) begin
              io_nxt  = CMD_COLCHG;
              cle_nxt = 1'b1;
              go      = 1'b1;
              col_nxt = COL_IN;
              chg_nxt = 2'h1;
            end else if (DATA_READY_OUT) begin
              io_nxt  = DATA_IN.data;
              go      = 1'b1;
              pos_nxt = DATA_IN.last ? pos_r + 4'h1 : pos_r;
            end
          end
          K_BUSY: begin
            cnt_nxt   = WB_C - 4'h1;
            state_nxt = ST_WB;
            pos_nxt   = pos_r + 4'h1;
          end
          K_STAT: begin
            re_nxt    = 1'b0;
            oe_nxt    = 1'b0;
            cnt_nxt   = REA_C - 4'h1;
            state_nxt = ST_RLOW;
            pos_nxt   = pos_r + 4'h1;
          end
          default: begin
            done_nxt  = 1'b1;
            state_nxt = ST_IDLE;
            if (req_r.op == OP_CB_READ) begin
              cbv_nxt = 1'b1;
              cbd_nxt = req_r.row_a[DIST_BIT];
            end else if (req_r.op != OP_STATUS) begin
              cbv_nxt = 1'b0;
            end
          end
        endcase
        if (go) begin
          we_nxt    = 1'b0;
          oe_nxt    = 1'b1;
          cnt_nxt   = WP_C - 4'h1;
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h0) begin
          we_nxt    = 1'b1;
          cnt_nxt   = WH_C - 4'h1;
          state_nxt = ST_HIGH;
        end
      end
      ST_HIGH, ST_RHIGH: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h0) begin
          cle_nxt   = 1'b0;
          ale_nxt   = 1'b0;
          oe_nxt    = 1'b0;
          state_nxt = ST_LOAD;
        end
      end
      ST_WB: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h0) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (rb_s2) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_RLOW: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h0) begin
          stat_nxt  = io_s2;
          re_nxt    = 1'b1;
          cnt_nxt   = WH_C - 4'h1;
          state_nxt = ST_RHIGH;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    ce_nxt = (state_nxt == ST_IDLE);
    wp_nxt = (state_nxt != ST_IDLE) || !PROTECT_IN;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
    end else begin
      rb_s1 <= RB_IN;
      rb_s2 <= rb_s1;
      io_s1 <= IO_IN;
      io_s2 <= io_s1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_IDLE;
      pos_r   <= 4'h0;
      cnt_r   <= 4'h0;
      acnt_r  <= 3'h0;
      chg_r   <= 2'h0;
      req_r   <= '0;
      col_r   <= '0;
      pgrow_r <= '0;
      pgcnt_r <= 3'h0;
      io_r    <= 8'h00;
      oe_r    <= 1'b0;
      cle_r   <= 1'b0;
      ale_r   <= 1'b0;
      we_r    <= 1'b1;
      re_r    <= 1'b1;
      ce_r    <= 1'b1;
      wp_r    <= 1'b0;
      stat_r  <= 8'h00;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      cbv_r   <= 1'b0;
      cbd_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r   <= pos_nxt;
      cnt_r   <= cnt_nxt;
      acnt_r  <= acnt_nxt;
      chg_r   <= chg_nxt;
      req_r   <= req_nxt;
      col_r   <= col_nxt;
      pgrow_r <= pgrow_nxt;
      pgcnt_r <= pgcnt_nxt;
      io_r    <= io_nxt;
      oe_r    <= oe_nxt;
      cle_r   <= cle_nxt;
      ale_r   <= ale_nxt;
      we_r    <= we_nxt;
      re_r    <= re_nxt;
      ce_r    <= ce_nxt;
      wp_r    <= wp_nxt;
      stat_r  <= stat_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      cbv_r   <= cbv_nxt;
      cbd_r   <= cbd_nxt;
    end
  end
endmodule : nps_ctrl
`default_nettype wire

/* rtl/nps_ctrl_sv_unused_marker.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verif/nps_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module nps_chk
  import nps_pkg::*;
#(
  parameter int MAX_PROG = MAX_PROG_DEF
) (
  input wire logic             CLK_IN,          // clock
  input wire logic             RST_N_IN,        // reset, low
  input wire logic             REQ_VALID_IN,    // request valid
  input wire nps_req_t         REQ_IN,          // request
  input wire logic             REQ_READY_OUT,   // idle
  input wire logic [COL_W-1:0] COL_IN,          // new column
  input wire logic             COL_CHG_ACK_OUT, // change taken
  input wire logic             DONE_OUT,        // finished
  input wire logic             ERR_OUT,         // refused
  input wire nps_pins_t        PINS_OUT,        // strobes
  input wire logic [7:0]       IO_OUT,          // io drive
  input wire logic             IO_OE_OUT,       // io enable
  input wire logic             RB_IN            // ready/busy
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire logic take = REQ_VALID_IN && REQ_READY_OUT;

  sequence s_wlow; !PINS_OUT.we_n [*2]; endsequence
  sequence s_whigh; PINS_OUT.we_n [*2]; endsequence
  property p_strobe; $fell(PINS_OUT.we_n) |-> s_wlow ##1 s_whigh; endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe shape wrong");
  // the byte is launched on the same edge as the strobe falls, so hold is checked after it
  property p_hold;
    $fell(PINS_OUT.we_n) |-> IO_OE_OUT ##1 (IO_OE_OUT && $stable(IO_OUT)) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("io byte not held over strobe");
  property p_excl; !(PINS_OUT.cle && PINS_OUT.ale); endproperty
  a_excl: assert property (p_excl) else $error("both latch strobes high");
  property p_ce; (!PINS_OUT.we_n || !PINS_OUT.re_n) |-> !PINS_OUT.ce_n; endproperty
  a_ce: assert property (p_ce) else $error("strobe without chip select");
  property p_read; !PINS_OUT.re_n |-> !IO_OE_OUT && PINS_OUT.we_n; endproperty
  a_read: assert property (p_read) else $error("bus driven during read");
  property p_wp; !PINS_OUT.we_n |-> PINS_OUT.wp_n; endproperty
  a_wp: assert property (p_wp) else $error("write protect low on a write");
  property p_col;
    take && REQ_IN.op == OP_PROG && REQ_IN.with_data && REQ_IN.col >= COL_PAGE_END
      |=> ERR_OUT && PINS_OUT.ce_n;
  endproperty
  a_col: assert property (p_col) else $error("parity column not refused");
  property p_dist;
    take && REQ_IN.op inside {OP_PROG2, OP_ERASE2}
      && REQ_IN.row_a[DIST_BIT] == REQ_IN.row_b[DIST_BIT] |=> ERR_OUT;
  endproperty
  a_dist: assert property (p_dist) else $error("same district pair not refused");
  property p_chg; COL_CHG_ACK_OUT |-> COL_IN < COL_PAGE_END; endproperty
  a_chg: assert property (p_chg) else $error("parity column change taken");
  property p_busy; !RB_IN [*3] |-> PINS_OUT.we_n; endproperty
  a_busy: assert property (p_busy) else $error("write strobe while busy");
  property p_done; DONE_OUT |=> !DONE_OUT && REQ_READY_OUT; endproperty
  a_done: assert property (p_done) else $error("done pulse or idle wrong");
endmodule : nps_chk

bind nps_ctrl nps_chk #(.MAX_PROG(MAX_PROG)) u_chk (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN),
  .REQ_READY_OUT(REQ_READY_OUT), .COL_IN(COL_IN), .COL_CHG_ACK_OUT(COL_CHG_ACK_OUT),
  .DONE_OUT(DONE_OUT), .ERR_OUT(ERR_OUT), .PINS_OUT(PINS_OUT), .IO_OUT(IO_OUT),
  .IO_OE_OUT(IO_OE_OUT), .RB_IN(RB_IN));
`default_nettype wire

/* verif/nps_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nps_dev
  import nps_pkg::*;
(
  input  wire nps_pins_t   pins,      // controller strobes
  input  wire logic [7:0]  io_drv,    // controller io drive
  input  wire logic        io_oe,     // controller io enable
  input  wire logic [1:0]  fail_mask, // districts that fail
  input  wire logic [15:0] bt_ns,     // busy time
  output logic [7:0]       bus,       // io level
  output logic             rb         // ready/busy
);
  logic [63:0] cmds, adrs, dats;
  logic [1:0]  hit, fres;
  logic [7:0]  st, lastv;
  logic        s71;
  int          acnt;
  wire logic   act = !pins.ce_n;

  initial begin
    {cmds, adrs, dats, hit, fres, lastv, s71} = '0;
    acnt = 0;
    rb = 1'b1;
  end
  // released bus shows the inverse of the last byte
  assign bus = io_oe ? io_drv : (act && !pins.re_n) ? st : ~lastv;
  assign st = {pins.wp_n, rb, rb, 2'b00, s71 ? fres : 2'b00, |fres};
  always @(posedge pins.re_n) lastv = st;
  always @(posedge pins.we_n) if (act) begin
    lastv = io_drv;
    if (pins.cle) begin
      if (io_drv inside {8'h80, 8'h00, 8'hff} || (io_drv == 8'h60 && cmds[7:0] != 8'h60))
        hit = '0;
      if (io_drv inside {8'h70, 8'h71}) s71 = io_drv[0];
      if (io_drv inside {8'h10, 8'hd0}) fres = hit & fail_mask;
      if (io_drv inside {8'h10, 8'h11, 8'hd0, 8'h35, 8'hff}) begin
        rb = 1'b0;
        rb <= #(bt_ns) 1'b1;
      end
      cmds = {cmds[55:0], io_drv};
      acnt = 0;
    end else if (pins.ale) begin
      if (acnt == (cmds[7:0] == 8'h60 ? 0 : 2)) hit[io_drv[6]] = 1'b1;
      adrs = {adrs[55:0], io_drv};
      acnt++;
    end else dats = {dats[55:0], io_drv};
  end
endmodule : nps_dev
`default_nettype wire

/* verif/test_nand_program_erase_ecc_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_nand_program_erase_ecc_sequencer
  import nps_pkg::*;
();
  logic             clk = 0, rst_n = 0, rv = 0, dv = 0, cc = 0, prot = 1;
  nps_req_t         req = '0;
  nps_data_t        din = '0;
  logic [COL_W-1:0] ccol = '0;
  logic [1:0]       fm = '0;
  logic [15:0]      bt = 16'd50;
  logic             rr, dr, ca, done, err, fail, oe, rb;
  logic [7:0]       stat, io, bus;
  nps_pins_t        pins;
  int               err_count = 0, checked = 0;

  always #4 clk = ~clk;

  nps_ctrl #(.MAX_PROG(2)) u_dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(rv), .REQ_IN(req), .REQ_READY_OUT(rr),
    .DATA_VALID_IN(dv), .DATA_IN(din), .DATA_READY_OUT(dr), .COL_CHG_IN(cc), .COL_IN(ccol),
    .COL_CHG_ACK_OUT(ca), .PROTECT_IN(prot), .DONE_OUT(done), .ERR_OUT(err),
    .STATUS_OUT(stat), .FAIL_OUT(fail), .PINS_OUT(pins), .IO_IN(bus), .IO_OUT(io),
    .IO_OE_OUT(oe), .RB_IN(rb));
  nps_dev u_dev (.pins(pins), .io_drv(io), .io_oe(oe), .fail_mask(fm), .bt_ns(bt),
    .bus(bus), .rb(rb));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // pg pages of n bytes; a column change before byte 1 of the first page when ccol is set
  task automatic feed(input int pg, input int n);
    for (int p = 0; p < pg; p++)
      for (int i = 0; i < n; i++) begin
        if (p == 0 && i == 1 && ccol != 0) begin
          cc <= 1'b1;
          dv <= 1'b0;
          do @(negedge clk); while (!ca);
          @(posedge clk);
          cc <= 1'b0;
        end
        din <= '{8'ha0 + 8'(p * 16 + i), i == n - 1};
        dv <= 1'b1;
        do @(negedge clk); while (!dr);
        @(posedge clk);
      end
    dv <= 1'b0;
  endtask : feed

  task automatic run(input nps_op_t op, input logic [COL_W-1:0] col,
                     input logic [ROW_W-1:0] ra, input logic [ROW_W-1:0] rw,
                     input logic wd, input int pg, input int n, input logic xe);
    req <= '{op, col, ra, rw, wd};
    rv <= 1'b1;
    do @(negedge clk); while (!rr);
    @(posedge clk);
    rv <= 1'b0;
    fork
      feed(pg, n);
    join_none
    repeat (4000) begin
      @(negedge clk);
      if (done || err) break;
    end
    disable fork;
    check({done, err}, {!xe, xe});
    @(posedge clk);
    dv <= 1'b0;
  endtask : run

  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk);
    check(pins, 6'b001110);
    rst_n <= 1'b1;
    ccol <= 13'h1010;
    // sector 1 main part, then its spare part, while protect is requested when idle
    run(OP_PROG, 13'h0200, 17'h10041, '0, 1'b1, 1, 3, 1'b0);
    check(u_dev.cmds[31:0], 32'h80851070);
    check(u_dev.adrs[39:0], 40'h4100011010);
    check(u_dev.dats[23:0], 24'ha0a1a2);
    check({stat, fail}, {8'he0, 1'b0});
    check(pins.wp_n, 1'b0);
    ccol <= '0;
    prot <= 1'b0;
    run(OP_PROG, '0, 17'h10041, '0, 1'b1, 1, 1, 1'b0);
    run(OP_PROG, '0, 17'h10041, '0, 1'b1, 1, 1, 1'b1);
    run(OP_PROG, 13'h1080, 17'h00300, '0, 1'b1, 1, 1, 1'b1);
    run(OP_PROG2, '0, 17'h00005, 17'h000c6, 1'b1, 2, 2, 1'b1);
    run(OP_ERASE2, '0, 17'h00080, 17'h00100, 1'b0, 0, 0, 1'b1);
    fm <= 2'b10;
    run(OP_PROG2, '0, 17'h00005, 17'h000c5, 1'b1, 2, 2, 1'b0);
    check(u_dev.cmds[39:0], 40'h8011811071);
    check(u_dev.dats[31:0], 32'ha0a1b0b1);
    check({stat, fail}, {8'he5, 1'b1});
    bt <= 16'd3000;
    fm <= 2'b01;
    run(OP_ERASE, '0, 17'h00080, '0, 1'b0, 0, 0, 1'b0);
    check(u_dev.cmds[23:0], 24'h60d070);
    check(u_dev.adrs[23:0], 24'h800000);
    check({stat, fail}, {8'he1, 1'b1});
    run(OP_ERASE2, '0, 17'h000c0, 17'h00080, 1'b0, 0, 0, 1'b0);
    check(u_dev.cmds[31:0], 32'h6060d071);
    check(stat, 8'he3);
    bt <= 16'd50;
    fm <= 2'b00;
    run(OP_CB_READ, '0, 17'h00141, '0, 1'b0, 0, 0, 1'b0);
    run(OP_CB_PROG, 13'h0010, 17'h00100, '0, 1'b1, 1, 1, 1'b1);
    run(OP_CB_PROG, 13'h0010, 17'h001c3, '0, 1'b1, 1, 1, 1'b0);
    check(u_dev.cmds[47:0], 48'h003570851070);
    run(OP_STATUS, '0, '0, '0, 1'b0, 0, 0, 1'b0);
    check({stat, fail}, {8'he0, 1'b0});
    run(OP_RESET, '0, '0, '0, 1'b0, 0, 0, 1'b0);
    check(u_dev.cmds[7:0], 8'hff);
    results();
  end
endmodule : test_nand_program_erase_ecc_sequencer
`default_nettype wire
